// File: rtl/usp_defines.svh
`ifndef USP_DEFINES_SVH
`define USP_DEFINES_SVH

// Register bit positions of the control inputs
`define USP_MCR_DTR_BIT       0
`define USP_MCR_RTS_BIT       1
`define USP_MCR_IRQ_EN_BIT    3
`define USP_IER_RTS_BIT       6
`define USP_IER_CTS_BIT       7
`define USP_EFR_AUTO_RTS_BIT  6
`define USP_EFR_AUTO_CTS_BIT  7
`define USP_XFR_HDX_EN_BIT    2
`define USP_XFR_HDX_INV_BIT   5

// Timing counts in sixteen-times baud ticks
`define USP_IR_PULSE_TICKS    4'h3
`define USP_IR_STRETCH_TICKS  5'h10
`define USP_BREAK_TICKS       160

// Reset levels of the pins
`define USP_TX_RST            1'h1
`define USP_RTS_N_RST         1'h1
`define USP_DTR_N_RST         1'h1

`endif

// File: rtl/usp_pkg.sv
package usp_pkg;

	// Control register images handed in by the host side
	typedef struct packed {
		logic [7:0] enhanced_feature_reg;
		logic [7:0] modem_control_reg;
		logic [7:0] interrupt_enable_reg;
		logic [7:0] extended_feature_reg;
	} usp_ctrl_t;

	// Interrupt pin group: value and enable per line
	typedef struct packed {
		logic [2:0] level;
		logic [2:0] oe;
	} usp_irq_t;

	// Transmit gate states
	typedef enum logic [0:0] {
		USP_TX_IDLE,
		USP_TX_SEND
	} usp_tx_state_t;

endpackage

// File: rtl/usp_serial_pins.sv
`timescale 1ns/1ps
`include "usp_defines.svh"
module usp_serial_pins
	import usp_pkg::*;
#(
	parameter int BREAK_TICKS = `USP_BREAK_TICKS
) (
	input  wire logic      clk,
	input  wire logic      rst_b,
	input  wire usp_ctrl_t ctrl,
	input  wire logic      ir_mode,
	input  wire logic      pc_mode,
	input  wire logic [1:0] irq_sel,
	input  wire logic [3:0] int_pending,
	input  wire logic      baud16_tick,
	input  wire logic      rclk_tick,
	input  wire logic      tx_char_req,
	input  wire logic      tx_char_end,
	input  wire logic      tx_bit,
	input  wire logic      tx_bit_start,
	input  wire logic      rx_above_trigger,
	input  wire logic      rx_pin,
	input  wire logic      cts_n,
	input  wire logic      line_fault_clr,
	output logic           tx_pin_ff,
	output logic           rx_data_ff,
	output logic           rx_clk_tick_ff,
	output logic           baud_clock_out_n_ff,
	output logic           tx_grant_ff,
	output logic           rts_n_ff,
	output logic           dtr_n_ff,
	output logic           line_fault_ff,
	output logic           flow_event_ff,
	output usp_irq_t       irq_pins_ff
);

	// Elaboration check: break threshold must fit the counter
	// A threshold below two ticks would flag a fault on a single glitch
	if (BREAK_TICKS < 2 || BREAK_TICKS > 65535) begin : g_bad_break
		$error("BREAK_TICKS out of range");
	end

	// Bit select helper, used for every single-bit control field
	function automatic logic fld(input logic [7:0] r, input int pos);
		fld = r[pos];
	endfunction

	// Decoded control bits
	wire auto_cts    = fld(ctrl.enhanced_feature_reg, `USP_EFR_AUTO_CTS_BIT);
	wire auto_rts    = fld(ctrl.enhanced_feature_reg, `USP_EFR_AUTO_RTS_BIT);
	wire sw_rts      = fld(ctrl.modem_control_reg, `USP_MCR_RTS_BIT);
	wire sw_dtr      = fld(ctrl.modem_control_reg, `USP_MCR_DTR_BIT);
	wire irq_en      = fld(ctrl.modem_control_reg, `USP_MCR_IRQ_EN_BIT);
	wire rts_evt_en  = fld(ctrl.interrupt_enable_reg, `USP_IER_RTS_BIT);
	wire cts_evt_en  = fld(ctrl.interrupt_enable_reg, `USP_IER_CTS_BIT);
	wire hdx_en      = fld(ctrl.extended_feature_reg, `USP_XFR_HDX_EN_BIT);
	wire hdx_inv     = fld(ctrl.extended_feature_reg, `USP_XFR_HDX_INV_BIT);

	// State
	usp_tx_state_t tx_state_ff;        // Transmit gate state
	usp_tx_state_t nxt_tx_state;       // Its next value
	logic          rts_armed_ff;       // Software has asserted RTS once
	logic [3:0]    ir_tx_cnt_ff;       // Infrared transmit pulse ticks left
	logic [4:0]    ir_rx_cnt_ff;       // Infrared receive stretch ticks left
	logic          rx_pin_d_ff;        // Previous receive level for edge
	logic [15:0]   busy_cnt_ff;        // Ticks receive sat off idle
	logic          cts_n_d_ff;         // Previous clear-to-send level

	// Transmit pin: plain data, or short high pulse per zero bit
	// A one bit sends no pulse in infrared mode, so the line idles low there
	// Normal mode passes the transmitter's bit through one clock late
	wire ir_pulse_start = tx_bit_start && !tx_bit;
	wire [3:0] nxt_ir_tx_cnt = ir_pulse_start ? `USP_IR_PULSE_TICKS :
		(baud16_tick && ir_tx_cnt_ff != 4'h0) ? ir_tx_cnt_ff - 4'h1 : ir_tx_cnt_ff;
	wire nxt_tx_pin = ir_mode ? (ir_tx_cnt_ff != 4'h0) : tx_bit;

	// Receive decode: infrared pulse becomes a zero held one bit time
	// Each rising edge restarts the stretch, so a pulse train merges into low bits
	// The edge register resets low, the infrared idle level, so reset makes no pulse
	wire rx_rise = rx_pin && !rx_pin_d_ff;
	wire [4:0] nxt_ir_rx_cnt = (ir_mode && rx_rise) ? `USP_IR_STRETCH_TICKS :
		(baud16_tick && ir_rx_cnt_ff != 5'h0) ? ir_rx_cnt_ff - 5'h1 : ir_rx_cnt_ff;
	wire nxt_rx_data = ir_mode ? !(rx_pin || ir_rx_cnt_ff != 5'h0) : rx_pin;

	// Line away from the idle level of the mode
	// Counter saturates instead of wrapping, so a stuck line flags only once unless BREAK_TICKS is 65535
	wire rx_off_idle = ir_mode ? rx_pin : !rx_pin;
	wire [15:0] nxt_busy_cnt = !rx_off_idle ? 16'h0000 :
		(baud16_tick && busy_cnt_ff != 16'hffff) ? busy_cnt_ff + 16'h0001 : busy_cnt_ff;
	wire fault_set = (busy_cnt_ff == 16'(BREAK_TICKS)) && baud16_tick;
	// Set wins over clear so no fault is lost
	wire nxt_line_fault = fault_set || (line_fault_ff && !line_fault_clr);

	// Receiver clock source: internal in PC mode
	// In PC mode the receiver needs no strap from the baud output
	wire nxt_rx_clk_tick = pc_mode ? baud16_tick : rclk_tick;

	// Transmit gate: stop only between characters
	// Trades up to one frame of extra transmit after a hold-off for clean frames
	wire cts_ok = !auto_cts || !cts_n;
	always_comb begin
		nxt_tx_state = tx_state_ff;
		case (tx_state_ff)
			USP_TX_IDLE: begin
				// Start a character only while clear-to-send allows
				if (tx_char_req && cts_ok) begin
					nxt_tx_state = USP_TX_SEND;
				end
			end
			USP_TX_SEND: begin
				// Ignore clear-to-send until the frame is out
				if (tx_char_end) begin
					nxt_tx_state = USP_TX_IDLE;
				end
			end
			default: begin
				nxt_tx_state = USP_TX_IDLE;
			end
		endcase
	end
	wire nxt_tx_grant = (nxt_tx_state == USP_TX_SEND);

	// Request-to-send selection
	// Arm bit remembers the first software assert since reset
	wire nxt_rts_armed = rts_armed_ff || sw_rts;
	wire auto_rts_on = auto_rts && sw_rts && rts_armed_ff;
	// Half-duplex wins over flow control: direction must follow the transmitter
	wire hdx_level = hdx_inv ? !tx_grant_ff : tx_grant_ff;
	wire nxt_rts_n = hdx_en ? !hdx_level :
		auto_rts_on ? rx_above_trigger :
		!sw_rts;

	// Flow line change events for the interrupt logic
	// One-cycle pulse per change; the host side latches it as a status event
	wire nxt_flow_event = (rts_evt_en && (nxt_rts_n != rts_n_ff)) ||
		(cts_evt_en && auto_cts && (cts_n != cts_n_d_ff));

	// Interrupt line: driven only when enabled and sources enabled
	// With no source enabled the line floats even when the modem bit is set
	// A select of three picks no line, so all three float
	wire irq_drive = irq_en && (ctrl.interrupt_enable_reg[3:0] != 4'h0);
	wire irq_level = |(int_pending & ctrl.interrupt_enable_reg[3:0]);
	usp_irq_t nxt_irq;
	genvar gi;
	for (gi = 0; gi < 3; gi++) begin : g_irq
		// Only the selected line leaves high impedance
		assign nxt_irq.oe[gi]    = irq_drive && (irq_sel == 2'(gi));
		assign nxt_irq.level[gi] = irq_level && (irq_sel == 2'(gi));
	end

	// Pin and flow state registers; reset holds transmit high
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Constants only in the reset branch
			tx_pin_ff    <= `USP_TX_RST;
			rts_n_ff     <= `USP_RTS_N_RST;
			dtr_n_ff     <= `USP_DTR_N_RST;
			tx_state_ff  <= USP_TX_IDLE;
			tx_grant_ff  <= 1'h0;
			rts_armed_ff <= 1'h0;
			ir_tx_cnt_ff <= 4'h0;
		end else begin
			tx_pin_ff    <= nxt_tx_pin;
			rts_n_ff     <= nxt_rts_n;
			dtr_n_ff     <= !sw_dtr;
			tx_state_ff  <= nxt_tx_state;
			tx_grant_ff  <= nxt_tx_grant;
			rts_armed_ff <= nxt_rts_armed;
			ir_tx_cnt_ff <= nxt_ir_tx_cnt;
		end
	end

	// Receive side registers; input ignored while in reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// Receive input is not looked at here
			rx_data_ff     <= 1'h1;
			rx_pin_d_ff    <= 1'h0;
			ir_rx_cnt_ff   <= 5'h00;
			busy_cnt_ff    <= 16'h0000;
			line_fault_ff  <= 1'h0;
			rx_clk_tick_ff <= 1'h0;
		end else begin
			rx_data_ff     <= nxt_rx_data;
			rx_pin_d_ff    <= rx_pin;
			ir_rx_cnt_ff   <= nxt_ir_rx_cnt;
			busy_cnt_ff    <= nxt_busy_cnt;
			line_fault_ff  <= nxt_line_fault;
			rx_clk_tick_ff <= nxt_rx_clk_tick;
		end
	end

	// Interrupt pins, baud output and flow events
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			// All interrupt lines float during reset
			irq_pins_ff         <= '0;
			baud_clock_out_n_ff <= 1'h1;
			flow_event_ff       <= 1'h0;
			cts_n_d_ff          <= 1'h1;
		end else begin
			irq_pins_ff         <= nxt_irq;
			baud_clock_out_n_ff <= !baud16_tick;
			flow_event_ff       <= nxt_flow_event;
			cts_n_d_ff          <= cts_n;
		end
	end

endmodule

// File: bench/usp_line_model.sv
`timescale 1ns/1ps
// Far end: idles the receive line and holds off the transmitter on command
module usp_line_model (
	input  wire logic ir_mode,
	input  wire logic brk,
	input  wire logic cts_hold,
	output logic      rx_pin,
	output logic      cts_n
);
	// Idle is high in normal mode and low in infrared; a break drives the other level
	assign rx_pin = brk ? ir_mode : !ir_mode;
	assign cts_n  = cts_hold;
endmodule

// File: bench/usp_serial_pins_properties.sv
`timescale 1ns/1ps
module usp_serial_pins_checker
	import usp_pkg::*;
(
	input wire logic       clk,
	input wire logic       rst_b,
	input wire usp_ctrl_t  ctrl,
	input wire logic       ir_mode,
	input wire logic       pc_mode,
	input wire logic [1:0] irq_sel,
	input wire logic       baud16_tick,
	input wire logic       rclk_tick,
	input wire logic       tx_bit,
	input wire logic       tx_char_end,
	input wire logic       cts_n,
	input wire logic       tx_pin_ff,
	input wire logic       rx_clk_tick_ff,
	input wire logic       tx_grant_ff,
	input wire logic       dtr_n_ff,
	input wire usp_irq_t   irq_pins_ff
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Interrupt drive condition and receiver clock source
	wire irq_on = ctrl.modem_control_reg[3] && (ctrl.interrupt_enable_reg[3:0] != 4'h0);
	wire rx_src = pc_mode ? baud16_tick : rclk_tick;
	property p_tx; $past(rst_b) && !ir_mode && !$past(ir_mode)
		|-> tx_pin_ff == $past(tx_bit); endproperty
	a_tx: assert property (p_tx) else $error("tx pin mismatch");
	property p_rxclk; $past(rst_b) |-> rx_clk_tick_ff == $past(rx_src); endproperty
	a_rxclk: assert property (p_rxclk) else $error("rx clock source wrong");
	property p_irq_en; $past(rst_b) && irq_pins_ff.oe != 3'h0 |-> $past(irq_on); endproperty
	a_irq_en: assert property (p_irq_en) else $error("irq driven while off");
	property p_irq_sel; $past(rst_b) && $past(irq_on) && $past(irq_sel) != 2'h3
		|-> irq_pins_ff.oe == 3'h1 << $past(irq_sel); endproperty
	a_irq_sel: assert property (p_irq_sel) else $error("irq line select wrong");
	property p_cts; $rose(tx_grant_ff) && $past(ctrl.enhanced_feature_reg[7])
		|-> !$past(cts_n); endproperty
	a_cts: assert property (p_cts) else $error("grant without clear to send");
	property p_hold; tx_grant_ff && !tx_char_end |=> tx_grant_ff; endproperty
	a_hold: assert property (p_hold) else $error("character cut short");
	property p_drop; tx_grant_ff && tx_char_end |=> !tx_grant_ff; endproperty
	a_drop: assert property (p_drop) else $error("grant kept after end");
	property p_dtr; $past(rst_b) |-> dtr_n_ff == !$past(ctrl.modem_control_reg[0]); endproperty
	a_dtr: assert property (p_dtr) else $error("terminal ready wrong");
endmodule
bind usp_serial_pins usp_serial_pins_checker i_chk (.clk, .rst_b, .ctrl, .ir_mode, .pc_mode,
	.irq_sel, .baud16_tick, .rclk_tick, .tx_bit, .tx_char_end, .cts_n, .tx_pin_ff,
	.rx_clk_tick_ff, .tx_grant_ff, .dtr_n_ff, .irq_pins_ff);

// File: bench/usp_serial_pins_bench.sv
`timescale 1ns/1ps
module usp_serial_pins_bench
	import usp_pkg::*;
;
	logic clk = 1'h0, rst_b, ir_mode, pc_mode, baud16_tick, rclk_tick, tx_bit, tx_char_req;
	logic tx_char_end, tx_bit_start, rx_above_trigger, line_fault_clr, brk, cts_hold, rx_pin;
	logic cts_n, tx_pin_ff, rx_data_ff, rx_clk_tick_ff, tx_grant_ff, rts_n_ff, dtr_n_ff;
	logic line_fault_ff, baud_clock_out_n_ff, flow_event_ff;
	usp_ctrl_t  ctrl;
	usp_irq_t   irq_pins_ff;
	logic [1:0] irq_sel;
	logic [3:0] int_pending;
	int         err_total = 0, checked = 0, cycles = 0;
	// Short break count keeps the line fault case to a few ticks
	usp_serial_pins #(.BREAK_TICKS(4)) i_dut (.clk, .rst_b, .ctrl, .ir_mode, .pc_mode, .irq_sel,
		.int_pending, .baud16_tick, .rclk_tick, .tx_char_req, .tx_char_end, .tx_bit,
		.tx_bit_start, .rx_above_trigger, .rx_pin, .cts_n, .line_fault_clr, .tx_pin_ff,
		.rx_data_ff, .rx_clk_tick_ff, .baud_clock_out_n_ff, .tx_grant_ff, .rts_n_ff,
		.dtr_n_ff, .line_fault_ff, .flow_event_ff, .irq_pins_ff);
	usp_line_model i_far (.ir_mode, .brk, .cts_hold, .rx_pin, .cts_n);
	always #12.5 clk = ~clk;
	// Run needs under a hundred cycles; a hang stops here
	always @(posedge clk) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			complete_run();
		end
	end
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Baud ticks as single-cycle pulses
	task automatic tick(input int n);
		repeat (n) begin
			baud16_tick = 1'h1;
			cyc(1);
			baud16_tick = 1'h0;
			cyc(1);
		end
	endtask
	task automatic char_end;
		tx_char_end = 1'h1;
		tx_char_req = 1'h0;
		cyc(1);
		tx_char_end = 1'h0;
		cyc(2);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	initial begin
		{ir_mode, pc_mode, baud16_tick, rclk_tick, tx_char_req, tx_char_end} = '0;
		{tx_bit_start, rx_above_trigger, line_fault_clr, brk, cts_hold, rst_b} = '0;
		{tx_bit, ctrl, irq_sel, int_pending} = {1'h1, 32'h0, 2'h3, 4'h0};
		cyc(10);
		rst_b = 1'h1;
		ctrl.modem_control_reg = 8'h01;
		tx_bit = 1'h0;
		cyc(2);
		chk("dtr_n", 3'h0, dtr_n_ff);
		chk("tx_norm", 3'h0, tx_pin_ff);
		rst_b = 1'h0;
		cyc(1);
		chk("tx_reset", 3'h1, tx_pin_ff);
		rst_b = 1'h1;
		ir_mode = 1'h1;
		tx_bit_start = 1'h1;
		cyc(1);
		{tx_bit_start, tx_bit} = 2'h1;
		cyc(2);
		chk("tx_ir_pulse", 3'h1, tx_pin_ff);
		tick(3);
		cyc(2);
		chk("tx_ir_idle", 3'h0, tx_pin_ff);
		chk("rx_ir_idle", 3'h1, rx_data_ff);
		brk = 1'h1;
		cyc(1);
		brk = 1'h0;
		cyc(2);
		chk("rx_ir_pulse", 3'h0, rx_data_ff);
		ir_mode = 1'h0;
		brk = 1'h1;
		tick(6);
		chk("fault_set", 3'h1, line_fault_ff);
		chk("rx_norm", 3'h0, rx_data_ff);
		{brk, line_fault_clr} = 2'h1;
		cyc(1);
		line_fault_clr = 1'h0;
		cyc(1);
		chk("fault_clr", 3'h0, line_fault_ff);
		// Each source pulses in turn; only the selected one may reach the receiver
		for (int m = 0; m < 4; m++) begin
			{pc_mode, rclk_tick, baud16_tick} = {m[1], m[0], !m[0]};
			cyc(1);
			chk("rx_clk", {2'h0, m[1] ^ m[0]}, rx_clk_tick_ff);
			chk("baud_out_n", {2'h0, m[0]}, baud_clock_out_n_ff);
		end
		{pc_mode, rclk_tick, baud16_tick} = 3'h0;
		{ctrl.enhanced_feature_reg, cts_hold, tx_char_req} = {8'h80, 2'h3};
		cyc(4);
		chk("grant_held", 3'h0, tx_grant_ff);
		cts_hold = 1'h0;
		cyc(2);
		chk("grant_go", 3'h1, tx_grant_ff);
		cts_hold = 1'h1;
		cyc(2);
		chk("grant_mid", 3'h1, tx_grant_ff);
		char_end();
		chk("grant_end", 3'h0, tx_grant_ff);
		{ctrl.extended_feature_reg, cts_hold, tx_char_req} = {8'h04, 2'h1};
		cyc(3);
		chk("rts_hdx_on", 3'h0, rts_n_ff);
		ctrl.extended_feature_reg = 8'h24;
		cyc(2);
		chk("rts_hdx_inv", 3'h1, rts_n_ff);
		ctrl.extended_feature_reg = 8'h04;
		char_end();
		chk("rts_hdx_off", 3'h1, rts_n_ff);
		{ctrl.extended_feature_reg, ctrl.enhanced_feature_reg} = 16'h0040;
		ctrl.interrupt_enable_reg = 8'h40;
		ctrl.modem_control_reg = 8'h03;
		cyc(3);
		chk("rts_armed", 3'h0, rts_n_ff);
		rx_above_trigger = 1'h1;
		cyc(1);
		chk("flow_event", 3'h1, flow_event_ff);
		cyc(2);
		chk("rts_full", 3'h1, rts_n_ff);
		chk("flow_event_end", 3'h0, flow_event_ff);
		{ctrl.modem_control_reg, ctrl.interrupt_enable_reg} = 16'h0b01;
		{irq_sel, int_pending} = 6'h11;
		cyc(2);
		chk("irq_oe", 3'h2, irq_pins_ff.oe);
		chk("irq_level", 3'h2, irq_pins_ff.level);
		ctrl.modem_control_reg = 8'h03;
		cyc(2);
		chk("irq_off", 3'h0, irq_pins_ff.oe);
		complete_run();
	end
endmodule
